// >>> dv/cpu_bus_model.sv
// cpu side of the peripheral bus: single-byte reads and writes
// assumes calls from the bench; strobes move at falling edges
`default_nettype none
module cpu_bus_model (
  input  wire logic        core_clk,
  input  wire logic [7:0]  bus_rdata,
  output var  logic [15:0] bus_addr,
  output var  logic        bus_wr, bus_rd,
  output var  logic [7:0]  bus_wdata
);
  timeunit 1ns / 1ps;
  initial {bus_addr, bus_wr, bus_rd, bus_wdata} = '0;
  // released data is inverted so a stale byte is never mistaken for valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk) {bus_addr, bus_wdata, bus_wr} = {a, d, 1'b1};
    @(negedge core_clk) {bus_wdata, bus_wr} = {~d, 1'b0};
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk) {bus_addr, bus_rd} = {a, 1'b1};
    @(negedge core_clk) {d, bus_rd} = {bus_rdata, 1'b0};
  endtask
endmodule
`default_nettype wire

// >>> dv/watchdog_overflow_reset_test.sv
// self-checking bench for the watchdog block with a short divider
// assumes cpu_bus_model and the bound checker are compiled first
`default_nettype none
module watchdog_overflow_reset_test;
  import wdt_pkg::*;
  timeunit 1ns / 1ps;
  localparam int DIV = 8;
  localparam logic [15:0] C = ADDR_CTRL_STATUS, T = ADDR_COUNTER;
  logic        core_clk = 0, resetn = 0, low_power_halt = 0;
  logic [15:0] bus_addr;
  logic        bus_wr, bus_rd, bus_hit, chip_reset_out;
  logic [7:0]  bus_wdata, bus_rdata, v;
  int          mismatches, checks, n;
  always #2 core_clk = ~core_clk;
  cpu_bus_model cpu_u (.core_clk, .bus_rdata, .bus_addr, .bus_wr, .bus_rd, .bus_wdata);
  watchdog_overflow_reset #(.DIV_RATIO(DIV)) dut_u (.core_clk, .resetn, .bus_addr,
    .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_hit, .low_power_halt, .chip_reset_out);
  task automatic ck(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t value differs", $time);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    cpu_u.rd(a, v);
    ck(v === e);
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    for (n = 0; n < lim && chip_reset_out !== lvl; n++) @(negedge core_clk);
    ck(chip_reset_out === lvl);
    if (chip_reset_out !== lvl) conclude();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    resetn = 1;
    rc(C, CTRL_STATUS_RESET);
    rc(T, COUNTER_RESET);
    cpu_u.wr(T, 8'h55);
    rc(T, 8'h00);
    cpu_u.wr(C, 8'h14);
    rc(C, 8'hba);
    rc(16'hffbd, 8'h00);
    cpu_u.wr(C, 8'h50);
    rc(C, 8'hfa);
    cpu_u.wr(T, 8'hfd);
    rc(T, 8'hfd);
    cpu_u.wr(C, 8'hb4);
    rc(C, 8'hfe);
    wait_rst(1'b1, 3 * DIV);
    ck(n >= 2 * DIV);
    rc(C, 8'hab);
    rc(T, 8'h00);
    wait_rst(1'b0, RESET_PULSE_CYCLES);
    rc(T, 8'h00);
    cpu_u.wr(C, 8'h10);
    cpu_u.wr(C, 8'hfc);
    rc(C, 8'hba);
    $display("overflow test done");
    cpu_u.wr(C, 8'hb4);
    low_power_halt = 1;
    repeat (3 * DIV) @(negedge core_clk);
    rc(T, 8'h00);
    low_power_halt = 0;
    repeat (2 * DIV + 2) @(negedge core_clk);
    rc(T, 8'h02);
    cpu_u.wr(C, 8'hb0);
    repeat (2 * DIV) @(negedge core_clk);
    rc(T, 8'h02);
    $display("halt test done");
    conclude();
  end
endmodule
`default_nettype wire

// >>> dv/wdt_chk_assertions.sv
// port-level checker for the watchdog block
// assumes a bind onto the block and a single core_clk domain
`default_nettype none
module wdt_chk (
  input wire logic        core_clk, resetn, bus_wr, bus_rd, bus_hit,
  input wire logic        low_power_halt, chip_reset_out,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata, bus_rdata
);
  timeunit 1ns / 1ps;
  logic [9:0] cnt_r;
  wire        rc = bus_rd && bus_addr == 16'hffbe;
  wire        rn = bus_rd && bus_addr == 16'hffbf;
  // counts sampled cycles of the internal reset pulse
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) cnt_r <= '0;
    else cnt_r <= chip_reset_out ? cnt_r + 10'h001 : '0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_hit_decode: assert property (bus_hit == (bus_addr[15:1] == 15'h7fdf))
    else $error("bad hit");
  a_pulse_len: assert property ($fell(chip_reset_out) |-> cnt_r == 10'h200)
    else $error("short pulse");
  a_pulse_max: assert property (cnt_r <= 10'h200) else $error("long pulse");
  a_inhibit_ones: assert property (rc |=> (bus_rdata & 8'haa) == 8'haa)
    else $error("inhibit bit low");
  a_unmapped_zero: assert property (bus_rd && !bus_hit |=> bus_rdata == 8'h00)
    else $error("unmapped data");
  a_rdata_hold: assert property (!bus_rd && !chip_reset_out |=> $stable(bus_rdata))
    else $error("rdata moved");
  a_count_cleared: assert property (chip_reset_out && rn |=> bus_rdata == 8'h00)
    else $error("count not zero");
  a_flag_kept: assert property (chip_reset_out && rc |=> bus_rdata == 8'hab)
    else $error("flag lost");
endmodule
bind watchdog_overflow_reset wdt_chk chk_u (.core_clk, .resetn, .bus_wr, .bus_rd, .bus_hit,
  .low_power_halt, .chip_reset_out, .bus_addr, .bus_wdata, .bus_rdata);
`default_nettype wire

// >>> rtl/watchdog_overflow_reset.sv
// watchdog: 8-bit up-counter on core_clk/8192, chip reset on overflow
// assumes the cpu bus is synchronous to core_clk and the oscillator
// clock equals core_clk; halt comes from the power-mode logic
`default_nettype none
module watchdog_overflow_reset
  import wdt_pkg::*;
#(
  parameter int DIV_RATIO = wdt_pkg::DIV_RATIO_DEFAULT
) (
  // clock and external reset pin
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // cpu peripheral bus
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic             bus_hit,
  // power mode: high in watch, subactive, subsleep and standby
  input  wire logic        low_power_halt,
  // internal chip reset request
  output logic             chip_reset_out
);
  import wdt_pkg::*;

  localparam int PW = $clog2(DIV_RATIO);
  localparam int RW = $clog2(RESET_PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(DIV_RATIO - 1);
  localparam logic [RW-1:0] PULSE_LEN  = RW'(RESET_PULSE_CYCLES);

  logic [7:0]    counter_r;
  logic [PW-1:0] presc_r;
  logic [RW-1:0] pulse_cnt_r;
  logic          cnt_we_r;
  logic          reg_we_r;
  logic          wd_on_r;
  logic          rst_flag_r;
  logic [7:0]    rdata_r;

  // address decode
  wire sel_ctrl  = (bus_addr == ADDR_CTRL_STATUS);
  wire sel_cnt   = (bus_addr == ADDR_COUNTER);
  wire wr_ctrl   = bus_wr && sel_ctrl;
  wire wr_cnt    = bus_wr && sel_cnt && cnt_we_r;
  wire in_reset  = (pulse_cnt_r != '0);
  wire running   = wd_on_r && !low_power_halt && !in_reset;
  wire tick      = running && (presc_r == PRESC_LAST);
  // a counter write in the same cycle as a tick wins; count resumes from it
  wire overflow  = tick && !wr_cnt && (counter_r == COUNTER_MAX);

  // inhibit bit must be written 0 in the same access
  wire upd_cnt_we = wr_ctrl && !bus_wdata[BIT_INH_CNT_WE];
  wire upd_reg_we = wr_ctrl && !bus_wdata[BIT_INH_REG_WE];
  wire upd_wd_on  = wr_ctrl && reg_we_r && !bus_wdata[BIT_INH_WD_ON];
  wire clr_flag   = wr_ctrl && reg_we_r && !bus_wdata[BIT_INH_RST_FLAG]
                    && !bus_wdata[BIT_RST_FLAG];

  // inhibit bits always read 1
  wire [7:0] ctrl_view = {1'b1, cnt_we_r, 1'b1, reg_we_r,
                          1'b1, wd_on_r, 1'b1, rst_flag_r};
  wire [7:0] rd_mux = sel_ctrl ? ctrl_view :
                      sel_cnt  ? counter_r : 8'h00;

  assign bus_rdata      = rdata_r;
  assign bus_hit        = sel_ctrl || sel_cnt;
  assign chip_reset_out = in_reset;

  // prescaler; frozen in low-power modes so the phase is kept
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_r <= '0;
    end else if (!running) begin
      presc_r <= in_reset ? '0 : presc_r;
    end else begin
      presc_r <= tick ? '0 : presc_r + 1'b1;
    end
  end

  // counter: write, else increment on tick; internal reset clears it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counter_r <= COUNTER_RESET;
    end else if (in_reset || overflow) begin
      counter_r <= COUNTER_RESET;
    end else if (wr_cnt) begin
      counter_r <= bus_wdata;
    end else if (tick) begin
      counter_r <= counter_r + 8'h01;
    end
  end

  // internal reset pulse length
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_cnt_r <= '0;
    end else if (overflow) begin
      pulse_cnt_r <= PULSE_LEN;
    end else if (in_reset) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  // control bits; the internal reset returns them to their reset values
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_we_r <= CTRL_STATUS_RESET[BIT_CNT_WE];
      reg_we_r <= CTRL_STATUS_RESET[BIT_REG_WE];
      wd_on_r  <= CTRL_STATUS_RESET[BIT_WD_ON];
    end else if (in_reset || overflow) begin
      cnt_we_r <= CTRL_STATUS_RESET[BIT_CNT_WE];
      reg_we_r <= CTRL_STATUS_RESET[BIT_REG_WE];
      wd_on_r  <= CTRL_STATUS_RESET[BIT_WD_ON];
    end else begin
      if (upd_cnt_we) begin
        cnt_we_r <= bus_wdata[BIT_CNT_WE];
      end
      if (upd_reg_we) begin
        reg_we_r <= bus_wdata[BIT_REG_WE];
      end
      if (upd_wd_on) begin
        wd_on_r <= bus_wdata[BIT_WD_ON];
      end
    end
  end

  // reset flag: the pin reset or a permitted software write of 0 clears it, the internal reset does not; set wins over a clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_flag_r <= CTRL_STATUS_RESET[BIT_RST_FLAG];
    end else if (overflow) begin
      rst_flag_r <= 1'b1;
    end else if (clr_flag) begin
      rst_flag_r <= 1'b0;
    end
  end

  // registered read data
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (bus_rd) begin
      rdata_r <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/wdt_pkg.sv
// watchdog register map, field positions, reset values and timing counts
// assumes an 8-bit peripheral bus with a 16-bit byte address
`default_nettype none
package wdt_pkg;
  localparam logic [15:0] ADDR_CTRL_STATUS = 16'hffbe;
  localparam logic [15:0] ADDR_COUNTER     = 16'hffbf;
  // control/status field positions
  localparam int BIT_INH_CNT_WE   = 7;
  localparam int BIT_CNT_WE       = 6;
  localparam int BIT_INH_REG_WE   = 5;
  localparam int BIT_REG_WE       = 4;
  localparam int BIT_INH_WD_ON    = 3;
  localparam int BIT_WD_ON        = 2;
  localparam int BIT_INH_RST_FLAG = 1;
  localparam int BIT_RST_FLAG     = 0;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'haa;
  localparam logic [7:0] COUNTER_RESET     = 8'h00;
  localparam logic [7:0] COUNTER_MAX       = 8'hff;
  // divided clock and internal reset length, in core_clk cycles
  localparam int DIV_RATIO_DEFAULT  = 8192;
  localparam int RESET_PULSE_CYCLES = 512;
endpackage
`default_nettype wire
